// ==== common/otpsl_map.vh ====
// constants for the otp security lock logic
`ifndef OTPSL_MAP_VH
`define OTPSL_MAP_VH
`define OTPSL_OP_RD_LOCK   8'h2B
`define OTPSL_OP_WR_LOCK   8'h2F
`define OTPSL_OP_ENTER     8'hB1
`define OTPSL_OP_EXIT      8'hC1
`define OTPSL_OP_WR_SR1    8'h01
`define OTPSL_OP_WR_SR2    8'h31
`define OTPSL_OP_PROG      8'h02
`define OTPSL_OP_ERASE_4K  8'h20
`define OTPSL_BIT_FACTORY  0
`define OTPSL_BIT_CUSTOMER 1
`define OTPSL_SN_LAST      24'h00000F
`define OTPSL_OTP_LAST     24'h0001FF
`endif

// ==== sim/otpsl_core_props.sv ====
// checker for the otp security lock logic
`timescale 1ns/1ps
`default_nettype none
module otpsl_core_props (
  input wire logic clk_sys_in, arst_n_in, clk_en_in, spi_sck_in, spi_cs_n_in, spi_mosi_in,
  input wire logic spi_miso_out, spi_miso_oe_out, nv_factory_lock_in, nv_customer_lock_in,
  input wire logic nv_customer_set_out, engine_busy_in, otp_mode_out, array_write_ok_out,
  input wire logic otp_write_ok_out, sn_region_out,
  input wire logic [7:0] lock_status_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  rsvd_zero_a: assert property (lock_status_out[7:2] == 6'h00)
    else $error("reserved bits set");
  fact_keep_a: assert property (lock_status_out[0] |=> lock_status_out[0])
    else $error("factory lock lost");
  cust_keep_a: assert property (lock_status_out[1] |=> lock_status_out[1])
    else $error("customer lock lost");
  main_block_a: assert property (otp_mode_out |-> !array_write_ok_out)
    else $error("array write in otp mode");
  otp_lock_a: assert property (|lock_status_out[1:0] |-> !otp_write_ok_out)
    else $error("otp write when locked");
  set_pulse_a: assert property (nv_customer_set_out |-> !lock_status_out[1] && !otp_mode_out
    && spi_cs_n_in ##1 !nv_customer_set_out) else $error("bad lock set");
  set_bit_a: assert property (nv_customer_set_out |=> ##[0:2] lock_status_out[1])
    else $error("lock bit not set");
  sn_mode_a: assert property (sn_region_out |-> otp_mode_out)
    else $error("serial region outside otp mode");
  owr_mode_a: assert property (otp_write_ok_out |-> otp_mode_out)
    else $error("otp write outside otp mode");
endmodule // otpsl_core_props
bind otpsl_core otpsl_core_props otpsl_core_props_i (.*);
`default_nettype wire

// ==== sim/otpsl_core_tb.sv ====
// testbench for the otp security lock logic
`timescale 1ns/1ps
`default_nettype none
module otpsl_core_tb;
  logic clk_sys_in = 1'h0, arst_n_in = 1'h0, clk_en_in = 1'h1, engine_busy_in = 1'h1;
  logic nv_factory_lock_in = 1'h0, nv_customer_lock_in = 1'h0;
  wire logic spi_sck_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_out;
  wire logic nv_customer_set_out, otp_mode_out, array_write_ok_out, otp_write_ok_out;
  wire logic sn_region_out;
  wire logic [7:0] lock_status_out;
  logic [7:0] r;
  int fails = 0, total_checks = 0, cyc = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  otpsl_core otpsl_core_i (.*);
  otpsl_host otpsl_host_i (.clk(clk_sys_in), .miso(spi_miso_out), .sck(spi_sck_in),
    .cs_n(spi_cs_n_in), .mosi(spi_mosi_in));
  // storage keeps what the block programs
  always @(negedge clk_sys_in) if (nv_customer_set_out) nv_customer_lock_in = 1'h1;
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task f(input logic [31:0] w, input int n);
    otpsl_host_i.frame(w, n, r);
  endtask
  // flags: otp mode, array ok, otp ok, serial region
  task st(input logic [3:0] e);
    chk({4'h0, otp_mode_out, array_write_ok_out, otp_write_ok_out, sn_region_out}, {4'h0, e});
  endtask
  always @(negedge clk_sys_in) if (++cyc == 20000) begin
    fails++;
    give_verdict;
  end
  task rst;
    arst_n_in = 1'h0;
    repeat (6) @(negedge clk_sys_in);
    arst_n_in = 1'h1;
    repeat (4) @(negedge clk_sys_in);
  endtask
  initial begin
    rst;
    f(32'h2B000000, 24); chk(r, 8'h00);
    chk({7'h00, spi_miso_oe_out}, 8'h00);
    st(4'h4);
    f(32'hB1000000, 8); f(32'h02000005, 32); st(4'hB);
    f(32'h020001FF, 32); st(4'hA);
    f(32'h02000200, 32); st(4'h8);
    f(32'h2F020000, 16); chk(lock_status_out, 8'h00);
    f(32'hC1000000, 8); st(4'h4);
    $display("otp mode test end");
    f(32'h2F020000, 19); chk(lock_status_out, 8'h00);
    f(32'h2F020000, 16); chk(lock_status_out, 8'h02);
    f(32'hB1000000, 8); f(32'h02000010, 32); st(4'h8);
    f(32'hC1000000, 8); f(32'h2B000000, 16); chk(r, 8'h02);
    $display("customer lock test end");
    nv_factory_lock_in = 1'h1;
    rst;
    f(32'h2B000000, 16); chk(r, 8'h03);
    f(32'hB1000000, 8); f(32'h02000005, 32); st(4'h9);
    $display("factory lock test end");
    give_verdict;
  end
endmodule // otpsl_core_tb
`default_nettype wire

// ==== sim/otpsl_host.sv ====
// spi host model issuing flash commands, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module otpsl_host (
  input wire logic clk,
  input wire logic miso,
  output var logic sck, cs_n, mosi
);
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end
  // sck stands low between frames; miso taken late in the high phase
  task automatic frame(input logic [31:0] w, input int n, output logic [7:0] r);
    @(negedge clk) cs_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      mosi = w[31-i];
      repeat (4) @(negedge clk);
      sck = 1'h1;
      repeat (4) @(negedge clk);
      r = {r[6:0], miso};
      sck = 1'h0;
    end
    repeat (4) @(negedge clk) cs_n = 1'h1;
    mosi = ~mosi;
    repeat (12) @(negedge clk);
  endtask
endmodule // otpsl_host
`default_nettype wire

// ==== verilog/otpsl_core.v ====
// otp security lock logic: spi command decode, lock status, otp mode
`timescale 1ns/1ps
`default_nettype none
`include "otpsl_map.vh"
module otpsl_core (
  // clock, reset, enable
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  input  wire        clk_en_in,
  // spi link pins
  input  wire        spi_sck_in,
  input  wire        spi_cs_n_in,
  input  wire        spi_mosi_in,
  output reg         spi_miso_out,
  output reg         spi_miso_oe_out,
  // nonvolatile lock storage
  input  wire        nv_factory_lock_in,
  input  wire        nv_customer_lock_in,
  output reg         nv_customer_set_out,
  // array engine status and grants
  input  wire        engine_busy_in,
  output reg         otp_mode_out,
  output reg         array_write_ok_out,
  output reg         otp_write_ok_out,
  output reg         sn_region_out,
  output reg  [7:0]  lock_status_out
);
////////////////////////////////////////////////////////////////////////////////
// pin synchronisers; first stage read only by second
reg [2:0] sck_s_q;
reg [1:0] cs_s_q;
reg [1:0] mosi_s_q;
always @(posedge clk_sys_in or negedge arst_n_in) begin
  if (!arst_n_in) begin
    sck_s_q  <= 3'h0;
    cs_s_q   <= 2'h3;
    mosi_s_q <= 2'h0;
  end else if (clk_en_in) begin
    sck_s_q  <= {sck_s_q[1:0], spi_sck_in};
    cs_s_q   <= {cs_s_q[0], spi_cs_n_in};
    mosi_s_q <= {mosi_s_q[0], spi_mosi_in};
  end
end
wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
wire cs_act   = ~cs_s_q[1];
////////////////////////////////////////////////////////////////////////////////
// shift in, byte count
localparam ST_LOAD = 2'h0;
localparam ST_IDLE = 2'h1;
localparam ST_CMD  = 2'h2;
reg [1:0]  st_q;
reg [2:0]  bit_q;
reg [7:0]  sh_q;
reg [7:0]  op_q;
reg [3:0]  nbytes_q;
reg [23:0] addr_q;
reg        fact_q;
reg        cust_q;
reg        otp_q;
reg        cs_act_q;
reg [7:0]  tx_q;
wire [7:0] sh_nx   = {sh_q[6:0], mosi_s_q[1]};
wire       byte_dn = sck_rise & cs_act & (bit_q == 3'h7);
wire       cs_rise = cs_act_q & ~cs_act;
wire       locked  = fact_q | cust_q;
wire [7:0] status  = {6'h00, cust_q, fact_q};
always @(posedge clk_sys_in or negedge arst_n_in) begin
  if (!arst_n_in) begin
    st_q     <= ST_LOAD;
    bit_q    <= 3'h0;
    sh_q     <= 8'h00;
    op_q     <= 8'h00;
    nbytes_q <= 4'h0;
    addr_q   <= 24'h000000;
    fact_q   <= 1'b0;
    cust_q   <= 1'b0;
    otp_q    <= 1'b0;
    cs_act_q <= 1'b0;
    tx_q     <= 8'h00;
    nv_customer_set_out <= 1'b0;
    spi_miso_out        <= 1'b0;
    spi_miso_oe_out     <= 1'b0;
    otp_mode_out        <= 1'b0;
    array_write_ok_out  <= 1'b0;
    otp_write_ok_out    <= 1'b0;
    sn_region_out       <= 1'b0;
    lock_status_out     <= 8'h00;
  end else if (clk_en_in) begin
    cs_act_q            <= cs_act;
    nv_customer_set_out <= 1'b0;
    case (st_q)
      // strap-like capture after reset release, before any command
      ST_LOAD: begin
        fact_q <= nv_factory_lock_in;
        cust_q <= nv_customer_lock_in;
        st_q   <= ST_IDLE;
      end
      ST_IDLE: begin
        bit_q    <= 3'h0;
        nbytes_q <= 4'h0;
        if (cs_act) begin
          st_q <= ST_CMD;
        end
      end
      default: begin
        if (sck_rise) begin
          bit_q <= bit_q + 3'h1;
          sh_q  <= sh_nx;
        end
        if (byte_dn) begin
          if (nbytes_q != 4'hF) begin
            nbytes_q <= nbytes_q + 4'h1;
          end
          if (nbytes_q == 4'h0) begin
            op_q <= sh_nx;
            if (sh_nx == `OTPSL_OP_RD_LOCK) begin
              tx_q <= status;
            end
          end else if (nbytes_q < 4'h4) begin
            addr_q <= {addr_q[15:0], sh_nx};
          end else if (op_q == `OTPSL_OP_RD_LOCK) begin
            tx_q <= status;
          end
        // the fall that closes a byte leaves the freshly loaded msb on the pin
        end else if (sck_fall && op_q == `OTPSL_OP_RD_LOCK && nbytes_q != 4'h0 &&
                     bit_q != 3'h0) begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
        // chip select end: execute on exact byte boundary only
        if (cs_rise) begin
          st_q <= ST_IDLE;
          if (bit_q == 3'h0) begin
            if (nbytes_q == 4'h1 && op_q == `OTPSL_OP_ENTER) begin
              otp_q <= 1'b1;
            end
            if (nbytes_q == 4'h1 && op_q == `OTPSL_OP_EXIT) begin
              otp_q <= 1'b0;
            end
            // no write enable needed; refused in otp mode or when customer lock already set (factory lock does not refuse)
            if (nbytes_q == 4'h2 && op_q == `OTPSL_OP_WR_LOCK && !otp_q &&
                !cust_q && sh_q[`OTPSL_BIT_CUSTOMER]) begin
              cust_q              <= 1'b1;
              nv_customer_set_out <= 1'b1;
            end
          end
        end
      end
    endcase
    spi_miso_oe_out <= cs_act && op_q == `OTPSL_OP_RD_LOCK && nbytes_q != 4'h0;
    spi_miso_out    <= tx_q[7];
    otp_mode_out    <= otp_q;
    // array writes blocked in otp mode; otp writes only when unlocked
    array_write_ok_out <= !otp_q && st_q != ST_LOAD;
    otp_write_ok_out   <= otp_q && !locked && addr_q <= `OTPSL_OTP_LAST;
    sn_region_out      <= otp_q && addr_q <= `OTPSL_SN_LAST;
    lock_status_out    <= status;
  end
end
// engine_busy_in does not gate status reads
wire unused_busy = engine_busy_in;
endmodule // otpsl_core
`default_nettype wire
